// ==== err_report_pkg.sv ====
// Package with register map, reset values and timing constants of the error reporting block.
`default_nettype none
package err_report_pkg;
    localparam logic [11:0] STATUS_OFF     = 12'h1CC;
    localparam logic [11:0] MASK_OFF       = 12'h1D0;
    localparam logic [11:0] CTRL_OFF       = 12'h1D4;
    localparam logic [11:0] TIMER_OFF      = 12'h1D8;
    localparam int          NUM_FLAGS      = 15;
    localparam logic [14:0] MASK_RESET     = 15'h7FFF;
    localparam logic [14:0] STATUS_RESET   = 15'h0000;
    localparam int          BIT_INGRESS_UE   = 8;
    localparam int          BIT_LINK_CE      = 9;
    localparam int          BIT_LINK_UE      = 10;
    localparam int          BIT_CREDIT_TMO   = 11;
    localparam int          BIT_UNDERRUN     = 12;
    localparam int          BIT_ALLOC_CE_OVF = 13;
    localparam int          BIT_ALLOC_UE     = 14;
    localparam int          BIT_CPL_OVF      = 0;
    localparam int          BIT_EG_PKT_OVF   = 1;
    localparam int          BIT_EG_LINK_OVF  = 2;
    localparam int          BIT_ALLOC_CNT_W  = 4;
    localparam logic [3:0]  ALLOC_CE_LIMIT   = 4'h8;
    localparam logic [8:0]  EGRESS_CE_LIMIT  = 9'h100;
    localparam longint      CLK_HZ         = 125000000;
    localparam longint      TMO_SHORT_MS   = 512;
    localparam longint      TMO_LONG_MS    = 1000;
    localparam longint      TMO_SHORT_CYC  = TMO_SHORT_MS * CLK_HZ / 1000;
    localparam longint      TMO_LONG_CYC   = TMO_LONG_MS * CLK_HZ / 1000;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage
`default_nettype wire

// ==== ram_ecc_error_status_mask.sv ====
// Sticky error status and mask registers with interrupt request, reached over AXI4-Lite.
// Notes on behaviour
// - An uncorrectable error read from the ingress packet RAM sets status bit 8.
// - A single-bit error in the ingress link-list RAM sets status bit 9.
// - An uncorrectable error in the ingress link-list RAM sets status bit 10.
// - When enabled, no useful credit update for 512 ms or 1 s sets status bit 11.
// - A credit underrun from the ingress credit handler sets status bit 12.
// - Eight or more single-bit errors in the ingress allocation RAM set status bit 13.
// - An uncorrectable error in the ingress allocation RAM sets status bit 14.
// - Status flags reset to zero, stay set, clear on a written one or a preload except bits 1, 2 and 13 while their counters hold, and survive soft reset.
// - The mask register is sticky read-write and may be preloaded.
// - Mask bit 0 cleared lets a completion FIFO overflow raise the interrupt.
// - Mask bits 1 to 14 when set keep the flag at the same position from raising the interrupt.
// - Mask bits 0 to 14 reset to one and bits 31 to 15 read as zero.
// - Every recorded error can raise the interrupt when enabled.
// - A completion FIFO overflow on either direction sets status bit 0.
// - Egress soft error counts of 256 or more set status bits 1 and 2.
//
// Local design decision: register access over AXI4-Lite.
`default_nettype none
module ram_ecc_error_status_mask #(
    parameter longint TMO_SHORT_CYCLES = err_report_pkg::TMO_SHORT_CYC,
    parameter longint TMO_LONG_CYCLES  = err_report_pkg::TMO_LONG_CYC
) (
    // Clock and resets.
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        soft_reset,
    // Preload of sticky state.
    input  wire logic        preload_valid,
    input  wire logic [14:0] preload_status,
    input  wire logic [14:0] preload_mask,
    // Error events, one-cycle pulses.
    input  wire logic [7:0]  low_error_events,
    input  wire logic        ingress_cpl_fifo_ovf,
    input  wire logic        egress_cpl_fifo_ovf,
    input  wire logic        egress_packet_ram_ce,
    input  wire logic        egress_link_list_ram_ce,
    input  wire logic        packet_ram_ue,
    input  wire logic        link_list_ram_ce,
    input  wire logic        link_list_ram_ue,
    input  wire logic        credit_update,
    input  wire logic        ingress_credit_handler_underrun,
    input  wire logic        ingress_alloc_unit_ce,
    input  wire logic        ingress_alloc_unit_ue,
    // AXI4-Lite slave.
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Interrupt request.
    output logic             irq
);
    localparam int N = err_report_pkg::NUM_FLAGS;

    logic [N-1:0]  status_ff, nxt_status;
    logic [N-1:0]  mask_ff, nxt_mask;
    logic [1:0]    ctrl_ff, nxt_ctrl;
    logic [31:0]   timer_ff, nxt_timer;
    logic [3:0]    alloc_cnt_ff, nxt_alloc_cnt;
    logic [8:0]    eg_pkt_cnt_ff, nxt_eg_pkt_cnt;
    logic [8:0]    eg_link_cnt_ff, nxt_eg_link_cnt;
    logic          irq_ff, nxt_irq;
    logic          aw_ff, nxt_aw, w_ff, nxt_w, b_ff, nxt_b, r_ff, nxt_r;
    logic          awrdy_ff, nxt_awrdy, wrdy_ff, nxt_wrdy, arrdy_ff, nxt_arrdy;
    logic [11:0]   awaddr_ff, nxt_awaddr;
    logic [31:0]   wdata_ff, nxt_wdata;
    logic [3:0]    wstrb_ff, nxt_wstrb;
    logic [1:0]    bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0]   rdata_ff, nxt_rdata;
    logic [N-1:0]  events;
    logic [31:0]   wmask;
    logic [31:0]   tmo_limit;
    logic          do_write;

    // Byte enables widened to a bit mask.
    for (genvar i = 0; i < 4; i++) begin : g_strb
        assign wmask[8*i +: 8] = {8{wstrb_ff[i]}};
    end

    assign do_write  = aw_ff && w_ff && !b_ff;
    // Switching to the shorter limit in mid-count may expire at once.
    assign tmo_limit = ctrl_ff[1] ? 32'(TMO_LONG_CYCLES) : 32'(TMO_SHORT_CYCLES);

    always_comb begin
        events                                     = {7'h00, low_error_events};
        events[err_report_pkg::BIT_CPL_OVF]        = low_error_events[0]
                                                     | ingress_cpl_fifo_ovf
                                                     | egress_cpl_fifo_ovf;
        // Counter flags re-set while the count holds, so only a full reset clears them.
        events[err_report_pkg::BIT_EG_PKT_OVF]     = low_error_events[1]
                                                     | eg_pkt_cnt_ff[8];
        events[err_report_pkg::BIT_EG_LINK_OVF]    = low_error_events[2]
                                                     | eg_link_cnt_ff[8];
        events[err_report_pkg::BIT_INGRESS_UE]     = packet_ram_ue;
        events[err_report_pkg::BIT_LINK_CE]        = link_list_ram_ce;
        events[err_report_pkg::BIT_LINK_UE]        = link_list_ram_ue;
        events[err_report_pkg::BIT_CREDIT_TMO]     = ctrl_ff[0] && !credit_update
                                                     && (timer_ff >= tmo_limit);
        events[err_report_pkg::BIT_UNDERRUN]       = ingress_credit_handler_underrun;
        events[err_report_pkg::BIT_ALLOC_CE_OVF]   =
            (alloc_cnt_ff >= err_report_pkg::ALLOC_CE_LIMIT);
        events[err_report_pkg::BIT_ALLOC_UE]       = ingress_alloc_unit_ue;
    end

    // Counters and timeout timer.
    always_comb begin
        nxt_alloc_cnt    = alloc_cnt_ff;
        nxt_eg_pkt_cnt   = eg_pkt_cnt_ff;
        nxt_eg_link_cnt  = eg_link_cnt_ff;
        nxt_timer        = timer_ff;
        // Counters saturate so a burst of errors cannot wrap back below the threshold.
        if (ingress_alloc_unit_ce && alloc_cnt_ff < err_report_pkg::ALLOC_CE_LIMIT) begin
            nxt_alloc_cnt = alloc_cnt_ff + 4'h1;
        end
        if (egress_packet_ram_ce && !eg_pkt_cnt_ff[8]) begin
            nxt_eg_pkt_cnt = eg_pkt_cnt_ff + 9'h001;
        end
        if (egress_link_list_ram_ce && !eg_link_cnt_ff[8]) begin
            nxt_eg_link_cnt = eg_link_cnt_ff + 9'h001;
        end
        // The timer restarts after each expiry so the flag re-arms for a later stall.
        if (!ctrl_ff[0] || credit_update || timer_ff >= tmo_limit) begin
            nxt_timer = 32'h0000_0000;
        end else begin
            nxt_timer = timer_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            alloc_cnt_ff    <= 4'h0;
            eg_pkt_cnt_ff   <= 9'h000;
            eg_link_cnt_ff  <= 9'h000;
            timer_ff        <= 32'h0000_0000;
        end else begin
            alloc_cnt_ff    <= nxt_alloc_cnt;
            eg_pkt_cnt_ff   <= nxt_eg_pkt_cnt;
            eg_link_cnt_ff  <= nxt_eg_link_cnt;
            timer_ff        <= nxt_timer;
        end
    end

    // Register file and AXI4-Lite handshake.
    always_comb begin
        nxt_status = status_ff;
        nxt_mask   = mask_ff;
        nxt_ctrl   = ctrl_ff;
        nxt_aw     = aw_ff;
        nxt_w      = w_ff;
        nxt_b      = b_ff;
        nxt_r      = r_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata  = wdata_ff;
        nxt_wstrb  = wstrb_ff;
        nxt_bresp  = bresp_ff;
        nxt_rresp  = rresp_ff;
        nxt_rdata  = rdata_ff;
        if (s_axi_awvalid && !aw_ff) begin
            nxt_aw     = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_ff) begin
            nxt_w     = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (do_write) begin
            nxt_b     = 1'b1;
            nxt_bresp = err_report_pkg::RESP_OKAY;
            unique case (awaddr_ff[11:2])
                err_report_pkg::STATUS_OFF[11:2]: begin
                    nxt_status = status_ff & ~(wdata_ff[N-1:0] & wmask[N-1:0]);
                end
                err_report_pkg::MASK_OFF[11:2]: begin
                    nxt_mask = (mask_ff & ~wmask[N-1:0])
                             | (wdata_ff[N-1:0] & wmask[N-1:0]);
                end
                err_report_pkg::CTRL_OFF[11:2]: begin
                    nxt_ctrl = (ctrl_ff & ~wmask[1:0]) | (wdata_ff[1:0] & wmask[1:0]);
                end
                err_report_pkg::TIMER_OFF[11:2]: begin
                    nxt_bresp = err_report_pkg::RESP_OKAY;
                end
                default: begin
                    nxt_bresp = err_report_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (b_ff && s_axi_bready) begin
            nxt_b  = 1'b0;
            nxt_aw = 1'b0;
            nxt_w  = 1'b0;
        end
        // A new event wins over a clear written in the same cycle.
        nxt_status = nxt_status | events;
        // Read data go out only after the address handshake, never alongside it.
        if (s_axi_arvalid && arrdy_ff) begin
            nxt_r     = 1'b1;
            nxt_rresp = err_report_pkg::RESP_OKAY;
            unique case (s_axi_araddr[11:2])
                err_report_pkg::STATUS_OFF[11:2]: nxt_rdata = {17'h00000, status_ff};
                err_report_pkg::MASK_OFF[11:2]:   nxt_rdata = {17'h00000, mask_ff};
                err_report_pkg::CTRL_OFF[11:2]:   nxt_rdata = {30'h00000000, ctrl_ff};
                err_report_pkg::TIMER_OFF[11:2]:  nxt_rdata = timer_ff;
                default: begin
                    nxt_rdata = 32'h0000_0000;
                    nxt_rresp = err_report_pkg::RESP_SLVERR;
                end
            endcase
        end else if (r_ff && s_axi_rready) begin
            nxt_r = 1'b0;
        end
        // Soft reset leaves sticky flags and mask alone; only control reverts.
        if (soft_reset) begin
            nxt_ctrl = 2'h0;
        end
        if (preload_valid) begin
            nxt_status = preload_status | events;
            nxt_mask   = preload_mask;
        end
        // Built from next values so the interrupt moves in the same cycle as the flags.
        nxt_irq = |(nxt_status & ~nxt_mask);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            status_ff <= err_report_pkg::STATUS_RESET;
            mask_ff   <= err_report_pkg::MASK_RESET;
            ctrl_ff   <= 2'h0;
            irq_ff    <= 1'b0;
            aw_ff     <= 1'b0;
            w_ff      <= 1'b0;
            b_ff      <= 1'b0;
            r_ff      <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
            bresp_ff  <= 2'h0;
            rresp_ff  <= 2'h0;
            rdata_ff  <= 32'h0000_0000;
        end else begin
            status_ff <= nxt_status;
            mask_ff   <= nxt_mask;
            ctrl_ff   <= nxt_ctrl;
            irq_ff    <= nxt_irq;
            aw_ff     <= nxt_aw;
            w_ff      <= nxt_w;
            b_ff      <= nxt_b;
            r_ff      <= nxt_r;
            awaddr_ff <= nxt_awaddr;
            wdata_ff  <= nxt_wdata;
            wstrb_ff  <= nxt_wstrb;
            bresp_ff  <= nxt_bresp;
            rresp_ff  <= nxt_rresp;
            rdata_ff  <= nxt_rdata;
        end
    end

    // Ready is a registered pulse one cycle after valid is first seen.
    // It pulses once per capture, so a valid that is still held is never taken twice.
    always_comb begin
        nxt_awrdy = s_axi_awvalid && !aw_ff && !awrdy_ff;
        nxt_wrdy  = s_axi_wvalid && !w_ff && !wrdy_ff;
        nxt_arrdy = s_axi_arvalid && !r_ff && !arrdy_ff;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            awrdy_ff <= 1'b0;
            wrdy_ff  <= 1'b0;
            arrdy_ff <= 1'b0;
        end else begin
            awrdy_ff <= nxt_awrdy;
            wrdy_ff  <= nxt_wrdy;
            arrdy_ff <= nxt_arrdy;
        end
    end

    assign s_axi_awready = awrdy_ff;
    assign s_axi_wready  = wrdy_ff;
    assign s_axi_arready = arrdy_ff;
    assign s_axi_bvalid  = b_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rvalid  = r_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign irq           = irq_ff;
endmodule
`default_nettype wire

// ==== err_status_chk.sv ====
// Checker with bus and interrupt assertions of the error status block.
`default_nettype none
module err_status_chk (
    // Clock and reset.
    input wire logic        mclk,
    input wire logic        arst_n,
    // Watched ports.
    input wire logic        preload_valid,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    aw_taken_a: assert property ($rose(s_axi_awvalid) |=> s_axi_awready && s_axi_wready)
        else $error("write not taken one cycle after valid");
    write_answer_a: assert property (s_axi_awready |=> s_axi_bvalid)
        else $error("write response missing after capture");
    b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    read_answer_a: assert property ($rose(s_axi_arvalid) |=> s_axi_arready ##1 s_axi_rvalid)
        else $error("read answer late");
    r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    refused_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("refused read returned data");
    reset_quiet_a: assert property ($rose(arst_n) |-> !irq [*4])
        else $error("interrupt raised right after reset");
    irq_fall_a: assert property ($fell(irq) |-> s_axi_bvalid || $past(preload_valid))
        else $error("interrupt dropped without a write");
    cover property ($rose(irq));
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind ram_ecc_error_status_mask err_status_chk err_status_chk_i (
    .mclk, .arst_n, .preload_valid, .s_axi_awvalid, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq
);
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the error status, mask and interrupt block.
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
    $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] ST = err_report_pkg::STATUS_OFF;
    localparam logic [11:0] MK = err_report_pkg::MASK_OFF;
    localparam logic [1:0]  OK = err_report_pkg::RESP_OKAY;
    localparam int          TS = 20;
    logic        mclk, arst_n, soft_reset, preload_valid, irq;
    logic [14:0] preload_status, preload_mask;
    logic [18:0] ev;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          failures = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          e;
    ram_ecc_error_status_mask #(.TMO_SHORT_CYCLES(TS), .TMO_LONG_CYCLES(2 * TS))
        ram_ecc_error_status_mask_i (
        .mclk, .arst_n, .soft_reset, .preload_valid, .preload_status, .preload_mask,
        .low_error_events(ev[7:0]), .packet_ram_ue(ev[8]), .link_list_ram_ce(ev[9]),
        .link_list_ram_ue(ev[10]), .credit_update(ev[11]),
        .ingress_credit_handler_underrun(ev[12]), .ingress_alloc_unit_ce(ev[13]),
        .ingress_alloc_unit_ue(ev[14]), .ingress_cpl_fifo_ovf(ev[15]),
        .egress_cpl_fifo_ovf(ev[16]), .egress_packet_ram_ce(ev[17]),
        .egress_link_list_ram_ce(ev[18]), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // A hang in any handshake wait ends here with a counted failure.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_sim;
        end
    end
    task automatic end_sim;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Address and data are released independently, each on its own ready.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa, pw, pb;
        pa = 1'b1;
        pw = 1'b1;
        pb = 1'b1;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa || pw || pb) begin
            @(posedge mclk);
            if (s_axi_awready) pa = 1'b0;
            if (s_axi_wready) pw = 1'b0;
            if (s_axi_bvalid) begin
                pb = 1'b0;
                `CHK(s_axi_bresp, er)
            end
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
            s_axi_bready <= pb;
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa, pr;
        pa = 1'b1;
        pr = 1'b1;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (pa || pr) begin
            @(posedge mclk);
            if (s_axi_arready) pa = 1'b0;
            if (s_axi_rvalid) begin
                pr = 1'b0;
                `CHK(s_axi_rdata, d)
                `CHK(s_axi_rresp, er)
            end
            s_axi_arvalid <= pa;
            s_axi_rready <= pr;
        end
    endtask
    task automatic pulse(input logic [18:0] v);
        @(posedge mclk);
        ev <= v;
        @(posedge mclk);
        ev <= '0;
    endtask
    // The interrupt is registered, so it is looked at one edge after the cause.
    task automatic settle;
        @(posedge mclk);
        #1;
    endtask
    initial begin
        {arst_n, soft_reset, preload_valid, preload_status, preload_mask, ev} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        settle;
        `CHK(irq, 1'b0)
        rd(MK, 32'h0000_7FFF, OK);
        rd(ST, 32'h0, OK);
        wr(MK, 32'hFFFF_FFFF, OK);
        rd(MK, 32'h0000_7FFF, OK);
        rd(12'h100, 32'h0, err_report_pkg::RESP_SLVERR);
        wr(12'h100, 32'h1, err_report_pkg::RESP_SLVERR);
        for (int i = 0; i < 17; i++) begin
            if (i == 11 || i == 13) continue;
            e = (i < 15) ? i : 0;
            pulse(19'(1) << i);
            rd(ST, 32'(1) << e, OK);
            `CHK(irq, 1'b0)
            wr(MK, 32'h7FFF ^ (32'(1) << e), OK);
            settle;
            `CHK(irq, 1'b1)
            wr(ST, 32'h0, OK);
            rd(ST, 32'(1) << e, OK);
            wr(ST, 32'(1) << e, OK);
            settle;
            `CHK(irq, 1'b0)
            rd(ST, 32'h0, OK);
            wr(MK, 32'h7FFF, OK);
        end
        pulse(19'h01000);
        @(posedge mclk);
        soft_reset <= 1'b1;
        @(posedge mclk);
        soft_reset <= 1'b0;
        rd(ST, 32'h1000, OK);
        rd(MK, 32'h7FFF, OK);
        @(posedge mclk);
        preload_status <= 15'h0005;
        preload_mask <= 15'h1234;
        preload_valid <= 1'b1;
        @(posedge mclk);
        preload_valid <= 1'b0;
        rd(ST, 32'h5, OK);
        rd(MK, 32'h1234, OK);
        `CHK(irq, 1'b1)
        wr(ST, 32'h5, OK);
        wr(MK, 32'h7FFF, OK);
        repeat (7) pulse(19'h02000);
        rd(ST, 32'h0, OK);
        pulse(19'h02000);
        rd(ST, 32'h2000, OK);
        repeat (255) pulse(19'h60000);
        rd(ST, 32'h2000, OK);
        pulse(19'h60000);
        rd(ST, 32'h2006, OK);
        for (int m = 0; m < 2; m++) begin
            pulse(19'h00800);
            wr(err_report_pkg::CTRL_OFF, 32'(1 + 2 * m), OK);
            repeat (TS * (1 + m) - 14) @(posedge mclk);
            rd(ST, 32'h2006, OK);
            repeat (12) @(posedge mclk);
            rd(ST, 32'h2806, OK);
            wr(ST, 32'h800, OK);
        end
        // A second full reset must clear the sticky flags and mask everything again.
        wr(MK, 32'h6FFF, OK);
        pulse(19'h01000);
        settle;
        `CHK(irq, 1'b1)
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        settle;
        `CHK(irq, 1'b0)
        rd(MK, 32'h0000_7FFF, OK);
        rd(ST, 32'h0, OK);
        end_sim;
    end
endmodule
`default_nettype wire
